/* include/gpled_pkg.sv */
// Constants, register map and carrier types of the pin and indicator block.
// Assumes a 40 MHz pclk and an APB master with 32-bit data and byte addresses.
package gpled_pkg;

	localparam int NUM_PINS = 12;
	localparam int NUM_IND = 8;
	localparam int ADDR_W = 12;

	// Register byte addresses
	localparam logic [11:0] ADDR_INDICATOR_CONFIG = 12'h1BC;
	localparam logic [11:0] ADDR_PIN_CONFIG = 12'h1E0;
	localparam logic [11:0] ADDR_PIN_DATA_DIR = 12'h1E4;
	localparam logic [11:0] ADDR_PIN_IRQ = 12'h1E8;
	localparam logic [11:0] ADDR_TOP_IRQ_STATUS = 12'h1F0;
	localparam logic [11:0] ADDR_TOP_IRQ_ENABLE = 12'h1F4;

	// Field positions
	localparam int DIR_LSB = 16;
	localparam int DATA_LSB = 0;
	localparam int IRQ_EN_LSB = 16;
	localparam int IRQ_FLAG_LSB = 0;
	localparam int POL_LSB = 16;
	localparam int TS_OE_LSB = 14;
	localparam int IND_FUNC_LSB = 8;
	localparam int IND_EN_LSB = 0;
	localparam int TOP_PIN_BIT = 12;

	// Reset values
	localparam logic [11:0] DIR_RST = 12'h000;
	localparam logic [11:0] DATA_RST = 12'h000;
	localparam logic [11:0] IRQ_EN_RST = 12'h000;
	localparam logic [11:0] FLAG_RST = 12'h000;
	localparam logic [11:0] POL_RST = 12'h000;
	localparam logic [1:0] TS_OE_RST = 2'h0;
	localparam logic [1:0] IND_FUNC_RST = 2'h0;
	localparam logic [7:0] IND_EN_RST = 8'h00;
	localparam logic TOP_EN_RST = 1'b0;

	// Timing: least level time of an interrupt input, rounded up to cycles
	localparam int CLK_PERIOD_NS = 25;
	localparam int IRQ_MIN_NS = 40;
	localparam int IRQ_MIN_CYC = (IRQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] IRQ_CNT_TOP = 2'(IRQ_MIN_CYC - 1);

	typedef enum logic [1:0] {
		GPLED_ST_RESET = 2'b00,
		GPLED_ST_SETTLE = 2'b01,
		GPLED_ST_LOAD = 2'b11,
		GPLED_ST_RUN = 2'b10
	} gpled_strap_state_t;

	typedef struct packed {
		logic [11:0] level;
		logic [11:0] enable;
	} gpled_pin_drv_t;

	typedef struct packed {
		logic [1:0] func;
		logic [7:0] enable;
	} gpled_strap_t;

	typedef struct packed {
		logic valid;
		logic [1:0] func;
		logic [7:0] enable;
	} gpled_loader_t;

endpackage

/* hw/gpled_sync.sv */
// Two-stage synchroniser for a bus of unrelated levels.
// Assumes each bit is an independent level; no word coherence is given.
module gpled_sync #(
	parameter int WIDTH = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule // gpled_sync

/* hw/gpled_top.sv */
// General purpose pins with indicator function, pin interrupts and APB registers.
// Assumes pins and straps are asynchronous; indicator, timestamp and loader inputs are on pclk.

// Operation
// - Twelve direction bits make each pin an input when clear and an output when set, reset to zero.
// - A general purpose output pin drives the value software wrote into its pin data bit.
// - Reading pin data returns the live pin for inputs and the written value for outputs.
// - Pins 11-10 take direction from their bits only; pins 9 and 8 also from the timestamp enables, pins 7-0 from the indicator enables.
// - Writing one to a pin interrupt flag clears it, writing zero leaves it, and all reset to zero.
// - Every enabled pin flag feeds one summary bit of the top interrupt status.
// - A set per-pin enable makes its flag a summary source, and enables reset to zero.
// - Pin flags are set by their triggers whatever the per-pin enable.
// - The interrupt pin rises for pin interrupts only when the top-level pin enable is set too.
// - Interrupt inputs are level sensitive and must hold the active level over 40 ns.
// - Each of eight indicator enable bits turns its low pin from general purpose to indicator.
// - The indicator function select output is zero unless at least one indicator enable is set.
// - Indicator function and enable reset values are latched from straps at reset release.
// - The configuration loader may replace the strapped indicator values after reset.
// - Each polarity bit selects whether a low or a high level sets the pin flag.
// - A set timestamp output enable makes pin 9 or 8 an output whatever its direction bit.
module gpled_top (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpled_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic [gpled_pkg::NUM_PINS-1:0] pin_in,
	output gpled_pkg::gpled_pin_drv_t pin_drv,
	// Timestamp event outputs for pins 9 and 8
	input wire logic [1:0] ts_event_level,
	// Indicator logic
	input wire logic [gpled_pkg::NUM_IND-1:0] indicator_level,
	output logic [1:0] indicator_function_select,
	output logic [gpled_pkg::NUM_IND-1:0] indicator_enable,
	// Straps and configuration loader
	input wire gpled_pkg::gpled_strap_t strap,
	input wire gpled_pkg::gpled_loader_t loader,
	// Host interrupt
	output logic irq
);
	import gpled_pkg::*;

	localparam int STRAP_W = $bits(gpled_strap_t);

	// Register state
	logic [NUM_PINS-1:0] pin_direction_bits_r;
	logic [NUM_PINS-1:0] pin_data_bits_r;
	logic [NUM_PINS-1:0] pin_irq_polarity_r;
	logic [NUM_PINS-1:0] irq_enable_r;
	logic [NUM_PINS-1:0] irq_flag_r;
	logic [NUM_PINS-1:0] irq_flag_nxt;
	logic [1:0] ts_oe_r;
	logic [1:0] ind_func_r;
	logic [NUM_IND-1:0] ind_en_r;
	logic top_irq_enable_r;
	logic irq_r;

	// Bus state
	logic [31:0] prdata_r;
	logic [31:0] rd_mux;
	logic took_r;
	logic unmapped;
	logic wr_fire;

	// Synchronised inputs
	logic [NUM_PINS-1:0] pin_sync;
	logic [STRAP_W-1:0] strap_sync;

	// Strap capture sequence
	gpled_strap_state_t strap_state_r;
	gpled_strap_state_t strap_state_nxt;

	// Derived pin control
	logic [NUM_PINS-1:0] eff_oe;
	logic [NUM_PINS-1:0] eff_level;
	logic [NUM_PINS-1:0] pin_read;
	logic [NUM_PINS-1:0] irq_active;
	logic [NUM_PINS-1:0] irq_hit;
	logic top_irq_status;
	gpled_pin_drv_t pin_drv_r;

	// Pin synchroniser
	gpled_sync #(
		.WIDTH(NUM_PINS)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d(pin_in),
		.q(pin_sync)
	);

	// Strap synchroniser
	gpled_sync #(
		.WIDTH(STRAP_W)
	) u_strap_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d(strap),
		.q(strap_sync)
	);

	// Straps are read after the release, once the synchroniser holds them
	always_comb begin
		case (strap_state_r)
			GPLED_ST_RESET: strap_state_nxt = GPLED_ST_SETTLE;
			GPLED_ST_SETTLE: strap_state_nxt = GPLED_ST_LOAD;
			GPLED_ST_LOAD: strap_state_nxt = GPLED_ST_RUN;
			GPLED_ST_RUN: strap_state_nxt = GPLED_ST_RUN;
			default: strap_state_nxt = GPLED_ST_RESET;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_state_r <= GPLED_ST_RESET;
		end else if (ce) begin
			strap_state_r <= strap_state_nxt;
		end
	end

	// APB decode
	always_comb begin
		case (paddr)
			ADDR_INDICATOR_CONFIG: unmapped = 1'b0;
			ADDR_PIN_CONFIG: unmapped = 1'b0;
			ADDR_PIN_DATA_DIR: unmapped = 1'b0;
			ADDR_PIN_IRQ: unmapped = 1'b0;
			ADDR_TOP_IRQ_STATUS: unmapped = 1'b0;
			ADDR_TOP_IRQ_ENABLE: unmapped = 1'b0;
			default: unmapped = 1'b1;
		endcase
	end

	// Read data is sampled every selected read cycle, so a frozen setup is caught up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			took_r <= 1'b0;
		end else if (ce) begin
			took_r <= psel & ~(penable & took_r);
		end
	end

	assign pready = psel & penable & took_r & ce;
	assign pslverr = pready & unmapped;
	assign wr_fire = pready & pwrite & ~unmapped;

	// Effective direction and level per pin
	always_comb begin
		eff_oe = pin_direction_bits_r;
		eff_level = pin_data_bits_r;
		eff_oe[9:8] = pin_direction_bits_r[9:8] | ts_oe_r;
		eff_level[9:8] = ts_event_level;
		for (int i = 8; i <= 9; i++) begin
			if (!ts_oe_r[i-8]) begin
				eff_level[i] = pin_data_bits_r[i];
			end
		end
		for (int i = 0; i < NUM_IND; i++) begin
			if (ind_en_r[i]) begin
				eff_oe[i] = 1'b1;
				eff_level[i] = indicator_level[i];
			end
		end
	end

	// Inputs show the pin, outputs the written value
	assign pin_read = (pin_data_bits_r & eff_oe) | (pin_sync & ~eff_oe);

	// Read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			ADDR_INDICATOR_CONFIG: begin
				rd_mux[IND_FUNC_LSB +: 2] = ind_func_r;
				rd_mux[IND_EN_LSB +: NUM_IND] = ind_en_r;
			end
			ADDR_PIN_CONFIG: begin
				rd_mux[POL_LSB +: NUM_PINS] = pin_irq_polarity_r;
				rd_mux[TS_OE_LSB +: 2] = ts_oe_r;
			end
			ADDR_PIN_DATA_DIR: begin
				rd_mux[DIR_LSB +: NUM_PINS] = pin_direction_bits_r;
				rd_mux[DATA_LSB +: NUM_PINS] = pin_read;
			end
			ADDR_PIN_IRQ: begin
				rd_mux[IRQ_EN_LSB +: NUM_PINS] = irq_enable_r;
				rd_mux[IRQ_FLAG_LSB +: NUM_PINS] = irq_flag_r;
			end
			ADDR_TOP_IRQ_STATUS: begin
				rd_mux[TOP_PIN_BIT] = top_irq_status;
			end
			ADDR_TOP_IRQ_ENABLE: begin
				rd_mux[TOP_PIN_BIT] = top_irq_enable_r;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (ce && psel && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	assign prdata = prdata_r;

	// Direction and data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction_bits_r <= DIR_RST;
			pin_data_bits_r <= DATA_RST;
		end else if (ce && wr_fire && paddr == ADDR_PIN_DATA_DIR) begin
			pin_direction_bits_r <= pwdata[DIR_LSB +: NUM_PINS];
			pin_data_bits_r <= pwdata[DATA_LSB +: NUM_PINS];
		end
	end

	// Polarity and timestamp output enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_irq_polarity_r <= POL_RST;
			ts_oe_r <= TS_OE_RST;
		end else if (ce && wr_fire && paddr == ADDR_PIN_CONFIG) begin
			pin_irq_polarity_r <= pwdata[POL_LSB +: NUM_PINS];
			ts_oe_r <= pwdata[TS_OE_LSB +: 2];
		end
	end

	// Indicator config: strap, then loader, then software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_func_r <= IND_FUNC_RST;
			ind_en_r <= IND_EN_RST;
		end else if (ce) begin
			if (strap_state_r == GPLED_ST_LOAD) begin
				ind_func_r <= strap_sync[IND_FUNC_LSB +: 2];
				ind_en_r <= strap_sync[IND_EN_LSB +: NUM_IND];
			end else if (loader.valid) begin
				ind_func_r <= loader.func;
				ind_en_r <= loader.enable;
			end else if (wr_fire && paddr == ADDR_INDICATOR_CONFIG) begin
				ind_func_r <= pwdata[IND_FUNC_LSB +: 2];
				ind_en_r <= pwdata[IND_EN_LSB +: NUM_IND];
			end
		end
	end

	// Function select is forced to zero only while no indicator enable is set
	assign indicator_function_select = (|ind_en_r) ? ind_func_r : 2'h0;
	assign indicator_enable = ind_en_r;

	// Per-pin enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_r <= IRQ_EN_RST;
		end else if (ce && wr_fire && paddr == ADDR_PIN_IRQ) begin
			irq_enable_r <= pwdata[IRQ_EN_LSB +: NUM_PINS];
		end
	end

	// Top-level pin interrupt enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_irq_enable_r <= TOP_EN_RST;
		end else if (ce && wr_fire && paddr == ADDR_TOP_IRQ_ENABLE) begin
			top_irq_enable_r <= pwdata[TOP_PIN_BIT];
		end
	end

	// Level qualifier: short glitches under the least time are ignored
	assign irq_active = ~(pin_sync ^ pin_irq_polarity_r);

	generate
		for (genvar g = 0; g < NUM_PINS; g++) begin : g_level
			logic [1:0] run_r;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					run_r <= 2'h0;
				end else if (ce) begin
					if (!irq_active[g]) begin
						run_r <= 2'h0;
					end else if (run_r != IRQ_CNT_TOP) begin
						run_r <= run_r + 2'h1;
					end
				end
			end

			assign irq_hit[g] = irq_active[g] && (run_r == IRQ_CNT_TOP);
		end
	endgenerate

	// Flags set regardless of enable; a set in the clear cycle wins
	always_comb begin
		irq_flag_nxt = irq_flag_r;
		if (wr_fire && paddr == ADDR_PIN_IRQ) begin
			irq_flag_nxt = irq_flag_r & ~pwdata[IRQ_FLAG_LSB +: NUM_PINS];
		end
		irq_flag_nxt = irq_flag_nxt | irq_hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_flag_r <= FLAG_RST;
		end else if (ce) begin
			irq_flag_r <= irq_flag_nxt;
		end
	end

	// Summary and host interrupt
	assign top_irq_status = |(irq_flag_r & irq_enable_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_r <= top_irq_status & top_irq_enable_r;
		end
	end

	assign irq = irq_r;

	// Pin drivers are registered to keep the pads glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_drv_r <= '0;
		end else if (ce) begin
			pin_drv_r.level <= eff_level;
			pin_drv_r.enable <= eff_oe;
		end
	end

	assign pin_drv = pin_drv_r;

endmodule // gpled_top

/* dv/gpled_pin_model.sv */
// Far side of the pins: resolves each pin from the block's drive and the outside level.
// Assumes push-pull drive and no pull resistors on the pins.
module gpled_pin_model (
	// Drive from the block
	input wire gpled_pkg::gpled_pin_drv_t pin_drv,
	// Level the outside world puts on undriven pins
	input wire logic [11:0] ext_level,
	// Resolved pin levels
	output logic [11:0] pin_in
);
	import gpled_pkg::*;
	// A driven pin shows the block's level, an undriven one the outside level
	assign pin_in = (pin_drv.level & pin_drv.enable) | (ext_level & ~pin_drv.enable);
endmodule // gpled_pin_model

/* dv/gpled_top_sva.sv */
// Checker for the pin and indicator block, bound to its top module.
// Assumes straps are held steady across reset.
module gpled_top_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins, indicators, straps
	input wire gpled_pkg::gpled_pin_drv_t pin_drv,
	input wire logic [gpled_pkg::NUM_IND-1:0] indicator_level,
	input wire logic [1:0] indicator_function_select,
	input wire logic [gpled_pkg::NUM_IND-1:0] indicator_enable,
	input wire gpled_pkg::gpled_strap_t strap,
	input wire gpled_pkg::gpled_loader_t loader
);
	import gpled_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	sequence s_boot;
		$rose(presetn) ##0 (ce && !loader.valid) [*3];
	endsequence
	a_ready_access: assert property (pready |-> psel && penable && ce)
		else $error("pready outside access");
	a_no_wait: assert property (s_setup ##1 (psel && penable && ce) |-> pready)
		else $error("unexpected wait state");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read data not zero");
	a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved idle");
	a_boot_inputs: assert property ($rose(presetn) |-> pin_drv.enable == 12'h000)
		else $error("pin driven after reset");
	a_strap_load: assert property (s_boot |=> indicator_enable == $past(strap.enable))
		else $error("strap not loaded");
	a_loader_load: assert property (loader.valid && ce && loader.enable != 8'h00 |=>
		indicator_enable == $past(loader.enable) && indicator_function_select == $past(loader.func))
		else $error("loader values not taken");
	a_func_gate: assert property (indicator_enable == 8'h00 |-> indicator_function_select == 2'h0)
		else $error("function select without enable");
	a_ind_drive: assert property (ce |=>
		(pin_drv.enable[7:0] & $past(indicator_enable)) == $past(indicator_enable) &&
		((pin_drv.level[7:0] ^ $past(indicator_level)) & $past(indicator_enable)) == 8'h00)
		else $error("indicator pin not driven");
endmodule // gpled_top_sva

bind gpled_top gpled_top_sva u_sva (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .pin_drv, .indicator_level, .indicator_function_select,
	.indicator_enable, .strap, .loader);

/* dv/gpled_top_tb.sv */
// Self-checking bench for the pin and indicator block over APB.
// Assumes the pin model resolves every pin; ce drops once to check the freeze.
module gpled_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import gpled_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr, pin_in, ext_level, dir, d;
	logic [31:0] pwdata, prdata, rs, q;
	logic [1:0] ts_event_level, indicator_function_select;
	logic [7:0] indicator_level, indicator_enable;
	gpled_pin_drv_t pin_drv;
	gpled_strap_t strap;
	gpled_loader_t loader;
	int errors, comparisons;

	gpled_top u_gpled_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pin_in, .pin_drv, .ts_event_level, .indicator_level,
		.indicator_function_select, .indicator_enable, .strap, .loader, .irq);
	gpled_pin_model u_gpled_pin_model (.pin_drv, .ext_level, .pin_in);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrap_up;
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string nm);
		comparisons++;
		if (s !== x) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask

	// Entered just after a rising edge; leaves one idle cycle behind
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never completes
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(1'h0, a, 32'h0);
		chk(q, x, nm);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end

	// About 4000 cycles, some 25 times what the sequence needs
	initial begin
		#100000;
		errors++;
		wrap_up();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ext_level, ts_event_level} = '0;
		ce = 1'h1;
		indicator_level = 8'h00;
		strap = '{2'h1, 8'h3C};
		loader = '0;
		rs = 32'hCAB65A3E;
		errors = 0;
		comparisons = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		idle(8);
		rd(ADDR_PIN_DATA_DIR, 32'h0, "data_dir");
		rd(ADDR_PIN_IRQ, 32'h0000_0FFF, "irq_flags");
		rd(ADDR_INDICATOR_CONFIG, 32'h0000_013C, "ind_cfg");
		rs = lfsr(rs);
		loader <= '{1'h1, 2'h3, 8'hA5};
		indicator_level <= rs[7:0];
		@(posedge pclk);
		loader <= '0;
		idle(2);
		chk(pin_drv.enable[7:0], 8'hA5, "ind_oe");
		chk(pin_drv.level[7:0] & 8'hA5, indicator_level & 8'hA5, "ind_level");
		chk(indicator_function_select, 2'h3, "ind_func");
		// A loader pulse while frozen must be lost
		ce <= 1'h0;
		loader <= '{1'h1, 2'h0, 8'hFF};
		@(posedge pclk);
		loader <= '0;
		ce <= 1'h1;
		@(posedge pclk);
		chk(indicator_enable, 8'hA5, "ind_en");
		rd(ADDR_INDICATOR_CONFIG, 32'h0000_03A5, "ind_cfg");
		apb(1'h1, ADDR_INDICATOR_CONFIG, 32'h0000_0300);
		chk(indicator_function_select, 2'h0, "ind_func");
		apb(1'h1, ADDR_PIN_CONFIG, 32'h0FFF_0000);
		apb(1'h1, ADDR_PIN_IRQ, 32'h0000_0FFF);
		rd(ADDR_PIN_IRQ, 32'h0, "irq_flags");
		ext_level <= 12'h008;
		@(posedge pclk);
		ext_level <= 12'h000;
		idle(6);
		rd(ADDR_PIN_IRQ, 32'h0, "irq_flags");
		ext_level <= 12'h008;
		idle(3);
		ext_level <= 12'h000;
		idle(6);
		rd(ADDR_PIN_IRQ, 32'h0000_0008, "irq_flags");
		rd(ADDR_TOP_IRQ_STATUS, 32'h0, "top_status");
		apb(1'h1, ADDR_PIN_IRQ, 32'h0008_0000);
		rd(ADDR_PIN_IRQ, 32'h0008_0008, "irq_flags");
		rd(ADDR_TOP_IRQ_STATUS, 32'h0000_1000, "top_status");
		chk(irq, 1'h0, "irq");
		apb(1'h1, ADDR_TOP_IRQ_ENABLE, 32'h0000_1000);
		idle(2);
		chk(irq, 1'h1, "irq");
		apb(1'h1, ADDR_PIN_IRQ, 32'h0008_0008);
		idle(2);
		chk(irq, 1'h0, "irq");
		for (int i = 0; i < 4; i++) begin
			rs = lfsr(rs);
			dir = rs[11:0];
			d = rs[23:12];
			rs = lfsr(rs);
			ext_level <= rs[11:0];
			apb(1'h1, ADDR_PIN_DATA_DIR, {4'h0, dir, 4'h0, d});
			idle(4);
			chk(pin_drv.enable, dir, "pin_oe");
			chk(pin_drv.level & dir, d & dir, "pin_level");
			rd(ADDR_PIN_DATA_DIR, {4'h0, dir, 4'h0, (d & dir) | (ext_level & ~dir)}, "data");
		end
		apb(1'h1, ADDR_PIN_DATA_DIR, 32'h0);
		ts_event_level <= 2'h2;
		apb(1'h1, ADDR_PIN_CONFIG, 32'h0000_C000);
		idle(2);
		chk(pin_drv.enable, 12'h300, "pin_oe");
		chk(pin_drv.level[9:8], 2'h2, "ts_level");
		apb(1'h0, 12'h004, 32'h0);
		chk(e, 1'h1, "pslverr");
		chk(q, 32'h0, "prdata");
		apb(1'h1, 12'h004, 32'hFFFF_FFFF);
		chk(e, 1'h1, "pslverr");
		rd(ADDR_PIN_DATA_DIR, {20'h0, ext_level & 12'hCFF}, "data_dir");
		// Second reset with new straps: they must be latched again
		presetn <= 1'h0;
		strap <= '{2'h2, 8'h5A};
		idle(2);
		presetn <= 1'h1;
		idle(8);
		chk(pin_drv.enable, 12'h05A, "pin_oe");
		rd(ADDR_INDICATOR_CONFIG, 32'h0000_025A, "ind_cfg");
		rd(ADDR_PIN_CONFIG, 32'h0, "pin_cfg");
		wrap_up();
	end
endmodule // gpled_top_tb
